// ### pkg/qps_pkg.sv
// Package: constants and types of the quad port power sequencer
package qps_pkg;
   localparam int NPORT = 4;
   localparam int CNT_W = 24;
   localparam int RT_W  = 7;
   localparam int IRQ_W = 13;
   // Clock and delays in their own units
   localparam int CLK_HZ      = 10_000_000;
   localparam int CYC_PER_US  = CLK_HZ / 1_000_000;
   localparam int T_SETTLE_US = 25_600;
   localparam int T_RELEASE_US = 3_200;
   localparam int T_OC_US     = 6_400;
   localparam int T_ARM_US    = 900_000;
   localparam int T_OPEN_US   = 25_600;
   localparam int SETTLE_CYC  = T_SETTLE_US * CYC_PER_US;
   localparam int RELEASE_CYC = T_RELEASE_US * CYC_PER_US;
   localparam int OC_CYC_DEF  = T_OC_US * CYC_PER_US;
   localparam int ARM_CYC     = T_ARM_US * CYC_PER_US;
   localparam int OPEN_CYC    = T_OPEN_US * CYC_PER_US;
   // Off-time in overcurrent units for 1%, 2%, 4% on-duty
   localparam logic [RT_W-1:0] OFF_UNITS_1 = 7'h63;
   localparam logic [RT_W-1:0] OFF_UNITS_2 = 7'h31;
   localparam logic [RT_W-1:0] OFF_UNITS_4 = 7'h18;
   // Three-level duty input codes; anything else means open
   localparam logic [1:0] DUTY_LOW  = 2'h0;
   localparam logic [1:0] DUTY_HIGH = 2'h3;
   // Register byte offsets
   localparam logic [7:0] REG_STATUS   = 8'h00;
   localparam logic [7:0] REG_IRQ_STAT = 8'h04;
   localparam logic [7:0] REG_IRQ_CLR  = 8'h08;
   localparam logic [7:0] REG_IRQ_EN   = 8'h0C;
   localparam logic [7:0] REG_CTRL     = 8'h10;
   // Event bit bases in the interrupt registers
   localparam int EV_OC   = 0;
   localparam int EV_OPEN = 4;
   localparam int EV_PEAK = 8;
   localparam int EV_SUP  = 12;

   typedef enum logic [2:0] {
      SW_OFF = 3'h0, SW_ON = 3'h1, SW_LATCH = 3'h3, SW_HOLD = 3'h2, SW_OPEN = 3'h6
   } qps_sw_type;
   typedef enum logic [1:0] {
      RLY_OFF = 2'h0, RLY_SETTLE = 2'h1, RLY_READY = 2'h3, RLY_RELEASE = 2'h2
   } qps_rly_type;

   // Pin inputs, as seen after synchronising
   typedef struct packed {
      logic [NPORT-1:0] sw_req, relay_req, cur_lim, peak, fully_on, low_cur;
      logic status_sel, open_en, auto_retry, lockout;
      logic [1:0] duty;
   } qps_pins_type;

   typedef struct packed {
      qps_sw_type       sw;
      qps_rly_type      rly;
      logic [CNT_W-1:0] rly_cnt, oc_cnt, ok_cnt;
      logic [RT_W-1:0]  rt_cnt;
      logic             armed, req_low;
   } qps_port_type;

   typedef struct packed {
      qps_pins_type                 s1, s2;
      qps_port_type [NPORT-1:0]     port;
      logic [CNT_W-1:0]             sup_cnt;
      logic [NPORT-1:0]             sw_on, rly_drv, gate_dis, fast_dis, stat, pg;
      logic                         fault_n, irq, ack, force_off;
      logic [IRQ_W-1:0]             irq_stat, irq_en;
      logic [31:0]                  dat;
   } qps_state_type;
endpackage

// ### hdl/qps_sequencer.sv
// Quad port power switch sequencer with Wishbone status and interrupts
// Contract
// - Switch on needs request, relay, settled supply
// - Relay rise: drive relay, wait settle delay
// - Relay fall: switch off, relay off later
// - Lockout holds all switches and relays off
// - Overcurrent over limit time latches, discharges gate
// - Auto-retry restarts after duty off-time
// - Power good: fully on, not limiting
// - Open detect armed after long good period
// - Global enable gates open detect everywhere
// - Per-port open flag shown on status
// - Relay drive polarity is a build option
// - Peak trip drives fast discharge at once
// - Duty input picks 1, 2, 4 percent
// - No retry: wait toggle and off-time
// - Shared fault low when any port latched
// - Selector picks power good or open flag
`timescale 1ns/100ps
`default_nettype none
module qps_sequencer
   import qps_pkg::*;
#(
   parameter int unsigned SETTLE  = SETTLE_CYC,  // Relay settle, supply settle
   parameter int unsigned RELEASE = RELEASE_CYC, // Relay release delay
   parameter int unsigned OC_CYC  = OC_CYC_DEF,  // Overcurrent time, timebase_set
   parameter int unsigned ARM     = ARM_CYC,     // Open detect arming delay
   parameter int unsigned OPEN    = OPEN_CYC,    // Open detect deglitch
   parameter bit RELAY_ACTIVE_LOW = 1'b1         // Sinking relay driver variant
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // Host control pins
   input  wire logic [NPORT-1:0] switch_request_i,
   input  wire logic [NPORT-1:0] relay_request_i,
   input  wire logic             status_select_i,
   input  wire logic             open_detect_enable_i,
   input  wire logic             auto_retry_enable_i,
   input  wire logic [1:0]       duty_select_i,
   // Analog comparators
   input  wire logic             supply_lockout_i,
   input  wire logic [NPORT-1:0] current_limit_i,
   input  wire logic [NPORT-1:0] peak_trip_i,
   input  wire logic [NPORT-1:0] fully_on_i,
   input  wire logic [NPORT-1:0] low_current_i,
   // Port drives and status
   output logic [NPORT-1:0]      switch_on_o,
   output logic [NPORT-1:0]      relay_drive_out_o,
   output logic [NPORT-1:0]      gate_discharge_o,
   output logic [NPORT-1:0]      fast_discharge_o,
   output logic [NPORT-1:0]      status_o,
   output logic                  fault_n_o,
   output logic                  irq_o,
   // Wishbone slave
   input  wire logic             wb_cyc_i,
   input  wire logic             wb_stb_i,
   input  wire logic             wb_we_i,
   input  wire logic [7:0]       wb_adr_i,
   input  wire logic [3:0]       wb_sel_i,
   input  wire logic [31:0]      wb_dat_i,
   output logic [31:0]           wb_dat_o,
   output logic                  wb_ack_o
);

   qps_state_type q;      // All state
   qps_state_type d;      // Next state
   qps_pins_type  pin_in; // Raw pins into the synchroniser
   qps_pins_type  p;      // Synchronised pins

   // Counter has run its full length
   function automatic logic done(input logic [CNT_W-1:0] cnt,
                                 input int unsigned lim);
      return cnt >= CNT_W'(lim);
   endfunction

   // Off-time units from the three-level duty input
   function automatic logic [RT_W-1:0] off_units(input logic [1:0] duty);
      if (duty == DUTY_LOW) begin
         return OFF_UNITS_1;
      end else if (duty == DUTY_HIGH) begin
         return OFF_UNITS_2;
      end
      return OFF_UNITS_4;
   endfunction

   // Byte lane mask from Wishbone select
   function automatic logic [31:0] lanes(input logic [3:0] sel);
      return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
   endfunction

   // Gather pins; all come from outside the clock domain
   always_comb begin
      pin_in.sw_req     = switch_request_i;
      pin_in.relay_req  = relay_request_i;
      pin_in.cur_lim    = current_limit_i;
      pin_in.peak       = peak_trip_i;
      pin_in.fully_on   = fully_on_i;
      pin_in.low_cur    = low_current_i;
      pin_in.status_sel = status_select_i;
      pin_in.open_en    = open_detect_enable_i;
      pin_in.auto_retry = auto_retry_enable_i;
      pin_in.lockout    = supply_lockout_i;
      pin_in.duty       = duty_select_i;
   end

   // Only the second stage is ever read
   assign p = q.s2;

   // Next state of the whole block
   always_comb begin
      logic                   settled;
      logic                   go;
      logic [IRQ_W-1:0]       ev;
      logic [31:0]            m;
      logic [31:0]            wv;
      logic [NPORT-1:0]       latched;
      d       = q;
      settled = 1'b0;
      go      = 1'b0;
      ev      = '0;
      m       = lanes(wb_sel_i);
      wv      = '0;
      latched = '0;
      d.s1    = pin_in;
      d.s2    = q.s1;

      // Supply must stay above threshold a full settle time
      if (p.lockout) begin
         d.sup_cnt = '0;
      end else if (!done(q.sup_cnt, SETTLE)) begin
         d.sup_cnt = q.sup_cnt + 1'b1;
      end
      settled = !p.lockout && done(q.sup_cnt, SETTLE);
      // Supply loss event fires once as the count collapses
      ev[EV_SUP] = p.lockout && done(q.sup_cnt, SETTLE);

      // Each port is a full copy; only global pins, the supply count and the force-off bit are shared
      for (int i = 0; i < NPORT; i++) begin
         // Relay sequencing
         unique case (q.port[i].rly)
            RLY_OFF: begin
               if (p.relay_req[i]) begin
                  d.port[i].rly     = RLY_SETTLE;
                  d.port[i].rly_cnt = '0;
               end
            end
            RLY_SETTLE: begin
               if (!p.relay_req[i]) begin
                  d.port[i].rly     = RLY_RELEASE;
                  d.port[i].rly_cnt = '0;
               end else if (done(q.port[i].rly_cnt, SETTLE)) begin
                  d.port[i].rly = RLY_READY;
               end else begin
                  d.port[i].rly_cnt = q.port[i].rly_cnt + 1'b1;
               end
            end
            RLY_READY: begin
               if (!p.relay_req[i]) begin
                  d.port[i].rly     = RLY_RELEASE;
                  d.port[i].rly_cnt = '0;
               end
            end
            RLY_RELEASE: begin
               // Contacts open only after the switch has been off a while
               if (done(q.port[i].rly_cnt, RELEASE)) begin
                  d.port[i].rly = RLY_OFF;
               end else begin
                  d.port[i].rly_cnt = q.port[i].rly_cnt + 1'b1;
               end
            end
         endcase
         if (p.lockout) begin
            d.port[i].rly = RLY_OFF;
         end

         // Remember a low request since the last latch
         if (!p.sw_req[i]) begin
            d.port[i].req_low = 1'b1;
         end
         // Relay request is read directly so a fall drops the switch at once
         go = p.sw_req[i] && p.relay_req[i] && q.port[i].rly == RLY_READY
              && settled && !q.force_off;

         // Switch state
         unique case (q.port[i].sw)
            SW_OFF: begin
               if (go) begin
                  d.port[i].sw     = SW_ON;
                  d.port[i].oc_cnt = '0;
                  d.port[i].ok_cnt = '0;
                  d.port[i].armed  = 1'b0;
               end
            end
            SW_ON: begin
               if (!go) begin
                  // Relay drop, lockout, host force-off or request low
                  d.port[i].sw = SW_OFF;
               end else if (p.cur_lim[i]) begin
                  d.port[i].ok_cnt = '0;
                  if (done(q.port[i].oc_cnt, OC_CYC)) begin
                     d.port[i].sw      = SW_LATCH;
                     d.port[i].oc_cnt  = '0;
                     d.port[i].rt_cnt  = '0;
                     d.port[i].req_low = 1'b0;
                     ev[EV_OC+i]       = 1'b1;
                  end else begin
                     d.port[i].oc_cnt = q.port[i].oc_cnt + 1'b1;
                  end
               end else begin
                  d.port[i].oc_cnt = '0;
                  if (!p.open_en) begin
                     // Disabled: drop arming at once
                     d.port[i].armed  = 1'b0;
                     d.port[i].ok_cnt = '0;
                  end else if (!q.port[i].armed) begin
                     if (!p.fully_on[i]) begin
                        d.port[i].ok_cnt = '0;
                     end else if (done(q.port[i].ok_cnt, ARM)) begin
                        d.port[i].armed  = 1'b1;
                        d.port[i].ok_cnt = '0;
                     end else begin
                        d.port[i].ok_cnt = q.port[i].ok_cnt + 1'b1;
                     end
                  end else if (!p.low_cur[i]) begin
                     d.port[i].ok_cnt = '0;
                  end else if (done(q.port[i].ok_cnt, OPEN)) begin
                     d.port[i].sw      = SW_OPEN;
                     d.port[i].req_low = 1'b0;
                     ev[EV_OPEN+i]     = 1'b1;
                  end else begin
                     d.port[i].ok_cnt = q.port[i].ok_cnt + 1'b1;
                  end
               end
            end
            SW_LATCH: begin
               // Off-time is counted in whole overcurrent periods
               if (done(q.port[i].oc_cnt, OC_CYC)) begin
                  d.port[i].oc_cnt = '0;
                  if (q.port[i].rt_cnt == off_units(p.duty) - 1'b1) begin
                     d.port[i].sw = p.auto_retry ? SW_OFF : SW_HOLD;
                  end else begin
                     d.port[i].rt_cnt = q.port[i].rt_cnt + 1'b1;
                  end
               end else begin
                  d.port[i].oc_cnt = q.port[i].oc_cnt + 1'b1;
               end
            end
            SW_HOLD: begin
               if (p.auto_retry || (q.port[i].req_low && p.sw_req[i])) begin
                  d.port[i].sw = SW_OFF;
               end
            end
            SW_OPEN: begin
               if (!p.sw_req[i]) begin
                  d.port[i].sw = SW_OFF;
               end
            end
            default: d.port[i].sw = SW_OFF;
         endcase

         // Registered port outputs
         latched[i] = d.port[i].sw inside {SW_LATCH, SW_HOLD, SW_OPEN};
         d.sw_on[i] = d.port[i].sw == SW_ON;
         d.pg[i] = d.sw_on[i] && p.fully_on[i] && !p.cur_lim[i];
         d.gate_dis[i] = d.port[i].sw inside {SW_LATCH, SW_HOLD};
         d.fast_dis[i] = p.peak[i];
         ev[EV_PEAK+i] = p.peak[i] && !q.fast_dis[i];
         d.stat[i] = p.status_sel ? d.pg[i] : d.port[i].sw == SW_OPEN;
         d.rly_drv[i] = (d.port[i].rly != RLY_OFF) ^ RELAY_ACTIVE_LOW;
      end

      // Shared fault line, also low under lockout
      d.fault_n = !(|latched || p.lockout);

      // Wishbone classic: answer one cycle after the request
      d.ack = wb_cyc_i && wb_stb_i && !q.ack;
      d.dat = '0;
      if (d.ack && wb_we_i) begin
         wv = wb_dat_i & m;
         unique case (wb_adr_i)
            REG_IRQ_CLR:  d.irq_stat = q.irq_stat & ~wv[IRQ_W-1:0];
            REG_IRQ_EN:   d.irq_en = (q.irq_en & ~m[IRQ_W-1:0]) | wv[IRQ_W-1:0];
            REG_CTRL:     d.force_off = m[0] ? wb_dat_i[0] : q.force_off;
            default:      d.dat = '0; // Unmapped or read-only: ignored
         endcase
      end else if (d.ack) begin
         unique case (wb_adr_i)
            REG_STATUS:   d.dat = {11'h000, settled, latched, q.stat & ~q.pg,
                                   q.pg, q.rly_drv ^ {NPORT{RELAY_ACTIVE_LOW}},
                                   q.sw_on};
            REG_IRQ_STAT: d.dat = {19'h00000, q.irq_stat};
            REG_IRQ_EN:   d.dat = {19'h00000, q.irq_en};
            REG_CTRL:     d.dat = {31'h00000000, q.force_off};
            default:      d.dat = '0;
         endcase
      end
      // New events win over a clear in the same cycle
      d.irq_stat = d.irq_stat | ev;
      d.irq      = |(d.irq_stat & d.irq_en);
   end

   // State register, synchronous reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q         <= '0;
         q.fault_n <= 1'b1;
         q.rly_drv <= {NPORT{RELAY_ACTIVE_LOW}};
      end else begin
         q <= d;
      end
   end

   // Outputs come straight from state flops
   assign switch_on_o       = q.sw_on;
   assign relay_drive_out_o = q.rly_drv;
   assign gate_discharge_o  = q.gate_dis;
   assign fast_discharge_o  = q.fast_dis;
   assign status_o          = q.stat;
   assign fault_n_o         = q.fault_n;
   assign irq_o             = q.irq;
   assign wb_dat_o          = q.dat;
   assign wb_ack_o          = q.ack;

endmodule // qps_sequencer
`default_nettype wire

// ### tb/qps_sequencer_asserts.sv
// Checker of the port sequencer pin behaviour
`timescale 1ns/100ps
`default_nettype none
module qps_sequencer_asserts
   import qps_pkg::*;
#(
   parameter bit RELAY_ACTIVE_LOW = 1'b1
) (
   // Clock, reset and watched pins
   input wire logic             clk_i,
   input wire logic             rst_i,
   input wire logic [NPORT-1:0] switch_request_i,
   input wire logic [NPORT-1:0] relay_request_i,
   input wire logic             supply_lockout_i,
   input wire logic [NPORT-1:0] current_limit_i,
   input wire logic [NPORT-1:0] peak_trip_i,
   input wire logic [NPORT-1:0] switch_on_o,
   input wire logic [NPORT-1:0] relay_drive_out_o,
   input wire logic [NPORT-1:0] gate_discharge_o,
   input wire logic [NPORT-1:0] fast_discharge_o,
   input wire logic             fault_n_o,
   input wire logic             wb_cyc_i,
   input wire logic             wb_stb_i,
   input wire logic             wb_ack_o,
   input wire logic [31:0]      wb_dat_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Port 0 relay driver enabled, either polarity
   wire logic rly_on0 = (relay_drive_out_o[0] == !RELAY_ACTIVE_LOW);
   // Lockout seen through the synchroniser forces every switch and relay off
   lockout_off_a: assert property (supply_lockout_i [*4] |-> switch_on_o == 4'h0
      && relay_drive_out_o == {NPORT{RELAY_ACTIVE_LOW}}) else $error("lockout left a port on");
   // Two sync stages plus the output flop: the switch reflects pins three samples back
   switch_gate_a: assert property (switch_on_o[0] |-> $past(relay_request_i[0], 3)
      && $past(switch_request_i[0], 3)) else $error("switch on without requests");
   // Relay must never open or close under load
   relay_first_a: assert property (switch_on_o[0] |-> rly_on0)
      else $error("switch on while relay off");
   relay_fall_a: assert property ($fell(relay_request_i[0]) |-> ##3 !switch_on_o[0])
      else $error("switch late off on relay fall");
   peak_fast_a: assert property (peak_trip_i[0] [*4] |-> fast_discharge_o[0])
      else $error("no fast discharge on peak");
   peak_idle_a: assert property (!peak_trip_i[0] [*4] |-> !fast_discharge_o[0])
      else $error("fast discharge without peak");
   // Window fits the shortened overcurrent count of six
   oc_latch_a: assert property ((switch_on_o[1] && current_limit_i[1]) [*8]
      |-> ##[0:6] gate_discharge_o[1]) else $error("overcurrent not latched");
   fault_low_a: assert property ($rose(|gate_discharge_o) |-> ##[0:1] !fault_n_o)
      else $error("latched port without fault");
   ack_pulse_a: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus answer not one pulse");
   idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
      else $error("read data outside answer");
endmodule // qps_sequencer_asserts
bind qps_sequencer qps_sequencer_asserts #(.RELAY_ACTIVE_LOW(RELAY_ACTIVE_LOW)) u_chk (
   .clk_i(clk_i), .rst_i(rst_i), .switch_request_i(switch_request_i),
   .relay_request_i(relay_request_i), .supply_lockout_i(supply_lockout_i),
   .current_limit_i(current_limit_i), .peak_trip_i(peak_trip_i), .switch_on_o(switch_on_o),
   .relay_drive_out_o(relay_drive_out_o), .gate_discharge_o(gate_discharge_o),
   .fast_discharge_o(fast_discharge_o), .fault_n_o(fault_n_o), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o));
`default_nettype wire

// ### tb/qps_host_model.sv
// Host controller model driving the per-port request pins
`timescale 1ns/100ps
`default_nettype none
module qps_host_model
   import qps_pkg::*;
(
   // Clock
   input  wire logic        clk_i,
   // Request pins toward the sequencer
   output logic [NPORT-1:0] switch_request_o,
   output logic [NPORT-1:0] relay_request_o
);
   // Both requests idle low from time zero
   initial begin
      switch_request_o = '0;
      relay_request_o = '0;
   end
   // Change one port's requests just after an edge
   task automatic drive(input int p, input logic rly, input logic sw);
      @(posedge clk_i);
      relay_request_o[p] <= rly;
      switch_request_o[p] <= sw;
   endtask
   // Low long enough to pass the synchroniser, then high again
   task automatic restart(input int p);
      drive(p, 1'b1, 1'b0);
      repeat (4) @(posedge clk_i);
      drive(p, 1'b1, 1'b1);
   endtask
endmodule // qps_host_model
`default_nettype wire

// ### tb/qps_sequencer_bench.sv
// Self-checking bench of the quad port sequencer
`timescale 1ns/100ps
`default_nettype none
module qps_sequencer_bench;
   import qps_pkg::*;
   logic             clk_i, rst_i, sel, oden, retry, lock, fault_n, irq;
   logic             cyc, stb, we, ack;
   logic [1:0]       duty;
   logic [3:0]       be;
   logic [7:0]       adr;
   logic [31:0]      wdat, rdat, q;
   logic [NPORT-1:0] swr, rlr, clim, peak, fon, lowc, sw_on, rly, gdis, fdis, stat;
   int               miscompares = 0;
   int               n_tests = 0;
   // Short counts keep the run small
   qps_host_model u_host (.clk_i(clk_i), .switch_request_o(swr), .relay_request_o(rlr));
   qps_sequencer #(.SETTLE(20), .RELEASE(8), .OC_CYC(6), .ARM(30), .OPEN(10)) u_dut (
      .clk_i(clk_i), .rst_i(rst_i), .switch_request_i(swr), .relay_request_i(rlr),
      .status_select_i(sel), .open_detect_enable_i(oden), .auto_retry_enable_i(retry),
      .duty_select_i(duty), .supply_lockout_i(lock), .current_limit_i(clim),
      .peak_trip_i(peak), .fully_on_i(fon), .low_current_i(lowc), .switch_on_o(sw_on),
      .relay_drive_out_o(rly), .gate_discharge_o(gdis), .fast_discharge_o(fdis),
      .status_o(stat), .fault_n_o(fault_n), .irq_o(irq), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(be), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack));
   // Compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic cyc_n(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // One classic bus cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s = 4'hF);
      int k;
      k = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      be <= s;
      do begin
         @(posedge clk_i);
         k++;
      end while (ack !== 1'b1 && k < 50);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      check(k < 50, 1);
   endtask
   task automatic tally_and_finish();
      if (miscompares == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Relay then switch on, host force-off, register view, relay fall
   task automatic t_relay();
      u_host.drive(0, 1'b1, 1'b1);
      cyc_n(5);
      check({rly[0], sw_on[0]}, 2'b00);
      cyc_n(30);
      check(sw_on[0], 1);
      // Lane 0 closed: the force bit must not move
      wb(1'b1, REG_CTRL, 32'h1, 4'h2);
      wb(1'b0, REG_CTRL, 0);
      check(q, 0);
      wb(1'b1, REG_CTRL, 32'h1);
      cyc_n(2);
      check(sw_on[0], 0);
      wb(1'b1, REG_CTRL, 0);
      cyc_n(2);
      check(sw_on[0], 1);
      wb(1'b0, REG_STATUS, 0);
      check(q, 32'h0010_0011);
      u_host.drive(0, 1'b0, 1'b1);
      cyc_n(4);
      check({rly[0], sw_on[0]}, 2'b00);
      cyc_n(12);
      check(rly[0], 1);
   endtask
   // Peak event raises, masks and clears the interrupt
   task automatic t_peak(input logic [31:0] en);
      wb(1'b1, REG_IRQ_EN, en);
      peak[0] <= 1'b1;
      cyc_n(4);
      check(fdis, 4'h1);
      check(irq, en[8]);
      peak[0] <= 1'b0;
      wb(1'b0, REG_IRQ_STAT, 0);
      check(q, 32'h100);
      wb(1'b1, REG_IRQ_CLR, 32'h1FFF);
      cyc_n(3);
      check({irq, fdis}, 5'h0);
   endtask
   // Overcurrent latch, then retry or host restart after the off-time
   task automatic t_oc(input logic [1:0] code, input int units, input logic auto);
      duty <= code;
      retry <= auto;
      u_host.drive(1, 1'b1, 1'b1);
      cyc_n(40);
      check(sw_on[1], 1);
      clim[1] <= 1'b1;
      cyc_n(14);
      check({sw_on, gdis, fault_n}, 9'h004);
      clim[1] <= 1'b0;
      if (!auto) u_host.restart(1);
      cyc_n(units * 7 - 30);
      check(sw_on[1], 0);
      cyc_n(60);
      check({sw_on[1], gdis[1], fault_n}, 3'b101);
      u_host.drive(1, 1'b0, 1'b0);
      cyc_n(20);
   endtask
   // Power good view, open detect arming, latch and global disable
   task automatic t_open();
      fon[3] <= 1'b1;
      lowc[3] <= 1'b1;
      oden <= 1'b1;
      sel <= 1'b1;
      u_host.drive(3, 1'b1, 1'b1);
      cyc_n(36);
      check(stat[3], 1);
      clim[3] <= 1'b1;
      cyc_n(4);
      check(stat[3], 0);
      clim[3] <= 1'b0;
      sel <= 1'b0;
      cyc_n(10);
      check({sw_on[3], stat[3]}, 2'b10);
      cyc_n(60);
      check({sw_on[3], stat[3], fault_n}, 3'b010);
      oden <= 1'b0;
      u_host.restart(3);
      cyc_n(6);
      check(stat[3], 0);
      cyc_n(80);
      check({sw_on[3], stat[3]}, 2'b10);
   endtask
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   // Watchdog well beyond the expected few thousand cycles
   initial begin
      cyc_n(20000);
      miscompares++;
      tally_and_finish();
   end
   // Main sequence
   initial begin
      {rst_i, sel, oden, retry, lock, duty} = 7'h41;
      {clim, peak, fon, lowc, cyc, stb, we, adr, wdat, be} = '0;
      cyc_n(8);
      rst_i <= 1'b0;
      check({sw_on, rly, gdis, fdis, stat, fault_n, irq}, 22'h03C002);
      wb(1'b0, 8'h40, 0);
      check(q, 0);
      wb(1'b1, REG_IRQ_EN, 32'hFFFF_FFFF);
      wb(1'b0, REG_IRQ_EN, 0);
      check(q, 32'h1FFF);
      // Only the low byte lane is written
      wb(1'b1, REG_IRQ_EN, 32'h0, 4'h1);
      wb(1'b0, REG_IRQ_EN, 0);
      check(q, 32'h1F00);
      cyc_n(30);
      t_relay();
      t_peak(32'h1FFF);
      t_peak(32'h0);
      t_oc(2'h0, 99, 1'b1);
      t_oc(2'h3, 49, 1'b1);
      t_oc(2'h1, 24, 1'b1);
      t_oc(2'h1, 24, 1'b0);
      t_open();
      lock <= 1'b1;
      cyc_n(5);
      check({sw_on, rly, fault_n}, 9'h1E);
      tally_and_finish();
   end
endmodule // qps_sequencer_bench
`default_nettype wire
